/* File: frcct_defines.svh */
// Purpose: Offsets, field positions, reset values and counts for the capture/compare timer
// Assumes: Registers reached over a plain address/strobe port, 16-bit data
// Notes:   Included by the prescaler, edge detector and timer design files
`ifndef FRCCT_DEFINES_SVH
`define FRCCT_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Register offsets
`define FRCCT_ADDR_W          4
`define FRCCT_OFF_CTL_A       4'h0
`define FRCCT_OFF_CTL_B       4'h1
`define FRCCT_OFF_OUT_CTL     4'h2
`define FRCCT_OFF_EDGE_CTL    4'h3
`define FRCCT_OFF_EXT_CTL     4'h4
`define FRCCT_OFF_OPTION      4'h5
`define FRCCT_OFF_CCR0        4'h6
`define FRCCT_OFF_CCR1        4'h7
`define FRCCT_OFF_COUNT       4'h8

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define FRCCT_CTL_A_RUN       7
`define FRCCT_CTL_A_CKS_LO    0
`define FRCCT_CTL_B_EXT_EVT   6
`define FRCCT_CTL_B_MODE_LO   0
`define FRCCT_OPT_WRAP        0
`define FRCCT_OPT_CCS0        4
`define FRCCT_OPT_CCS1        5
`define FRCCT_OUT_EN0         0
`define FRCCT_OUT_EN1         2

////////////////////////////////////////////////////////////////////////////////
// Mode encodings and reset values
`define FRCCT_MODE_PWM        3'h4
`define FRCCT_MODE_FREE       3'h5
`define FRCCT_RST_REG8        8'h00
`define FRCCT_RST_REG16       16'h0000
`define FRCCT_CNT_MAX         16'hFFFF
`define FRCCT_CNT_ZERO        16'h0000
`define FRCCT_RST_CNT         16'hFFFF

`endif

/* File: frcct_pkg.sv */
// Purpose: Shared types of the capture/compare timer
// Assumes: Constants live in frcct_defines.svh
// Notes:   Bus request travels as one packed struct
package frcct_pkg;

    typedef struct packed {
        logic [3:0]  addr;   // Register offset
        logic [15:0] wdata;  // Write data
        logic        wr;     // Write strobe
        logic        rd;     // Read strobe
    } frcct_bus_req_t;

    typedef struct packed {
        logic [1:0] edge_sel;  // 00 none, 01 rising, 10 falling, 11 both
    } frcct_edge_cfg_t;

endpackage

/* File: frcct_prescale.sv */
// Purpose: Count-clock enable from internal prescaler or external event edge
// Assumes: ext_evt already synchronised by the caller
// Notes:   One-cycle pulse per count clock
`timescale 1ns/10ps
`include "frcct_defines.svh"
module frcct_prescale
(
    input  wire logic       clk,        // Module clock
    input  wire logic       rst,        // Synchronous reset, high
    input  wire logic [2:0] clk_sel,    // Division select, 2^n
    input  wire logic       ext_sel,    // Count external events
    input  wire logic       ext_evt,    // Synchronised event edge pulse
    output logic            count_en    // Count clock enable
);
    import frcct_pkg::*;

    logic [7:0] div_cnt;
    logic       tick;

    ////////////////////////////////////////////////////////////////////////////
    // Free divider; the tap chooses the rate
    always_ff @(posedge clk)
    begin
        if (rst)
            div_cnt <= `FRCCT_RST_REG8;
        else
            div_cnt <= div_cnt + 8'h01;
    end

    // Tap all-ones of the low bits; sel 0 ticks every cycle
    always_comb
    begin
        tick = 1'b1;
        for (int i = 0; i < 7; i++)
            if (i < int'(clk_sel))
                tick = tick & div_cnt[i];
    end

    // External event overrides the clock selection
    assign count_en = ext_sel ? ext_evt : tick;
endmodule // frcct_prescale

/* File: frcct_edge_det.sv */
// Purpose: Synchronise a pin and flag its selected valid edge
// Assumes: Pin is asynchronous to clk
// Notes:   Two-flop synchroniser, edge taken from the second and third stage
`timescale 1ns/10ps
`include "frcct_defines.svh"
module frcct_edge_det
(
    input  wire logic                     clk,      // Module clock
    input  wire logic                     rst,      // Synchronous reset, high
    input  wire logic                     pin,      // Raw pin
    input  wire frcct_pkg::frcct_edge_cfg_t cfg,    // Edge selection
    output logic                          edge_hit  // One-cycle valid edge pulse
);
    import frcct_pkg::*;

    logic meta;
    logic sync;
    logic prev;

    ////////////////////////////////////////////////////////////////////////////
    // First stage read only by the second
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end
        else
        begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    // Rising and falling enabled independently
    assign edge_hit = (cfg.edge_sel[0] & sync & ~prev) | (cfg.edge_sel[1] & ~sync & prev);
endmodule // frcct_edge_det

/* File: frcct_timer.sv */
// Purpose: 16-bit free-running capture/compare timer with two channels
// Assumes: Registers over a plain port, read data one cycle after the strobe
// Notes:   Event outputs are one-cycle pulses from flops
//
// Behaviour
// - In PWM mode the channel 1 match interrupt fires on the equal cycle.
// - Otherwise the channel 1 interrupt fires on the count-up after equality.
// - Mode field value 101 selects free-running operation.
// - Run bit starts counting; option bits pick compare or capture per channel.
// - Starting the count inverts both toggle outputs.
// - Compare match raises the channel interrupt and, in free-running or PWM mode, toggles its pin, no clear.
// - Except for channel 1 in PWM mode, interrupt and toggle occur when the counter reaches value plus one.
// - After FFFFH, next count wraps to zero, raises overflow, sets wrap flag.
// - Channel register writes are compared from the next cycle, unbuffered.
// - Capture edge latches the count and raises the channel interrupt.
// - Count readback register returns the live counter while running, zero while stopped.
// - External event counting makes the clock selection irrelevant.
// - The two channel registers work independently.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`include "frcct_defines.svh"
module frcct_timer
(
    input  wire logic                   clk,                // Module clock, 10 MHz
    input  wire logic                   rst,                // Synchronous reset, high
    input  wire frcct_pkg::frcct_bus_req_t bus,             // Register request
    output logic [15:0]                 rdata,              // Read data, cycle after rd
    input  wire logic                   chan0_capture_in,   // Capture pin 0, also event input
    input  wire logic                   chan1_capture_in,   // Capture pin 1
    output logic                        chan0_toggle_out,   // Toggle output 0
    output logic                        chan0_toggle_oe,    // Output enable 0
    output logic                        chan1_toggle_out,   // Toggle output 1
    output logic                        chan1_toggle_oe,    // Output enable 1
    output logic                        chan0_match_capture_irq, // Channel 0 event pulse
    output logic                        chan1_match_irq,    // Channel 1 event pulse
    output logic                        counter_wrap_irq    // Overflow pulse
);
    import frcct_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Register state
    logic [7:0]  timer_control_reg_a;
    logic [7:0]  timer_control_reg_b;
    logic [7:0]  output_control_reg;
    logic [7:0]  capture_edge_control_reg;
    logic [7:0]  external_input_control_reg;
    logic        chan0_capture_select;
    logic        chan1_capture_select;
    logic        counter_wrap_flag;
    logic [15:0] ccr [2];
    logic [15:0] count;

    logic        count_run_bit;
    logic [2:0]  timer_op_mode_field;
    logic        external_event_select;
    logic        count_en;
    logic        run_d;
    logic        start_pulse;
    logic        free_mode;
    logic        pwm_mode;
    logic        wrap_evt;
    logic [1:0]  cap_hit;
    logic [1:0]  eq_now;
    logic        first_cnt;
    logic [1:0]  match_evt;
    logic [1:0]  capsel;
    logic [1:0]  ccr_wr;
    logic        opt_wr;
    logic        evt_edge;

    assign count_run_bit         = timer_control_reg_a[`FRCCT_CTL_A_RUN];
    assign timer_op_mode_field   = timer_control_reg_b[`FRCCT_CTL_B_MODE_LO +: 3];
    assign external_event_select = timer_control_reg_b[`FRCCT_CTL_B_EXT_EVT];
    assign free_mode = (timer_op_mode_field == `FRCCT_MODE_FREE);
    assign pwm_mode  = (timer_op_mode_field == `FRCCT_MODE_PWM);
    assign capsel    = {chan1_capture_select, chan0_capture_select};

    // Decode used for both channel registers and option writes
    function automatic logic hit(input frcct_bus_req_t b, input logic [3:0] off);
        hit = b.wr && (b.addr == off);
    endfunction

    assign opt_wr = hit(bus, `FRCCT_OFF_OPTION);
    assign ccr_wr = {hit(bus, `FRCCT_OFF_CCR1), hit(bus, `FRCCT_OFF_CCR0)};

    ////////////////////////////////////////////////////////////////////////////
    // Pin front ends; channel 0 pin also serves as the event input
    frcct_edge_det u_edge0
    (
        .clk      (clk),
        .rst      (rst),
        .pin      (chan0_capture_in),
        .cfg      (frcct_edge_cfg_t'(capture_edge_control_reg[1:0])),
        .edge_hit (cap_hit[0])
    );

    frcct_edge_det u_edge1
    (
        .clk      (clk),
        .rst      (rst),
        .pin      (chan1_capture_in),
        .cfg      (frcct_edge_cfg_t'(capture_edge_control_reg[3:2])),
        .edge_hit (cap_hit[1])
    );

    frcct_edge_det u_edge_evt
    (
        .clk      (clk),
        .rst      (rst),
        .pin      (chan0_capture_in),
        .cfg      (frcct_edge_cfg_t'(external_input_control_reg[1:0])),
        .edge_hit (evt_edge)
    );

    frcct_prescale u_prescale
    (
        .clk      (clk),
        .rst      (rst),
        .clk_sel  (timer_control_reg_a[`FRCCT_CTL_A_CKS_LO +: 3]),
        .ext_sel  (external_event_select),
        .ext_evt  (evt_edge),
        .count_en (count_en)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Plain control registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            timer_control_reg_a        <= `FRCCT_RST_REG8;
            timer_control_reg_b        <= `FRCCT_RST_REG8;
            output_control_reg         <= `FRCCT_RST_REG8;
            capture_edge_control_reg   <= `FRCCT_RST_REG8;
            external_input_control_reg <= `FRCCT_RST_REG8;
            chan0_capture_select       <= 1'b0;
            chan1_capture_select       <= 1'b0;
        end
        else if (bus.wr)
        begin
            case (bus.addr)
                `FRCCT_OFF_CTL_A:    timer_control_reg_a <= bus.wdata[7:0];
                `FRCCT_OFF_CTL_B:    timer_control_reg_b <= bus.wdata[7:0];
                `FRCCT_OFF_OUT_CTL:  output_control_reg <= bus.wdata[7:0];
                `FRCCT_OFF_EDGE_CTL: capture_edge_control_reg <= bus.wdata[7:0];
                `FRCCT_OFF_EXT_CTL:  external_input_control_reg <= bus.wdata[7:0];
                `FRCCT_OFF_OPTION:
                begin
                    chan0_capture_select <= bus.wdata[`FRCCT_OPT_CCS0];
                    chan1_capture_select <= bus.wdata[`FRCCT_OPT_CCS1];
                end
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Run edge; counting is held in reset while stopped
    always_ff @(posedge clk)
    begin
        if (rst)
            run_d <= 1'b0;
        else
            run_d <= count_run_bit;
    end

    assign start_pulse = count_run_bit & ~run_d;
    assign wrap_evt = count_run_bit && !first_cnt && count_en && (count == `FRCCT_CNT_MAX);

    // Counter parks at FFFFH so the first count clock after start gives zero
    always_ff @(posedge clk)
    begin
        if (rst || !count_run_bit)
            count <= `FRCCT_RST_CNT;
        else if (count_en)
            count <= count + 16'h0001; // wraps naturally, never cleared
    end

    // High until the first count clock after start; leaving the parked FFFFH is no wrap
    always_ff @(posedge clk)
    begin
        if (rst || !count_run_bit)
            first_cnt <= 1'b1;
        else if (count_en)
            first_cnt <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Match detection per channel; compares live register, no buffer
    generate
        for (genvar m = 0; m < 2; m++)
        begin : g_chan
            assign eq_now[m] = count_run_bit && !capsel[m] && (count == ccr[m]);

            // Capture wins over a software write of the same register
            always_ff @(posedge clk)
            begin
                if (rst)
                    ccr[m] <= `FRCCT_RST_REG16;
                else if (capsel[m] && count_run_bit && cap_hit[m])
                    ccr[m] <= count;
                else if (ccr_wr[m])
                    ccr[m] <= bus.wdata;
            end
        end
    endgenerate

    // Channel 0 on the count-up that leaves Dm, so the event shows with Dm+1
    assign match_evt[0] = eq_now[0] && count_en;
    // Channel 1 in PWM mode one count earlier, on the count-up into Dm
    assign match_evt[1] = pwm_mode ? (count_run_bit && !capsel[1] && count_en
                                      && (count + 16'h0001 == ccr[1]))
                                   : (eq_now[1] && count_en);

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt pulses, registered
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            chan0_match_capture_irq <= 1'b0;
            chan1_match_irq         <= 1'b0;
            counter_wrap_irq        <= 1'b0;
        end
        else
        begin
            chan0_match_capture_irq <= capsel[0] ? (count_run_bit && cap_hit[0])
                                                 : match_evt[0];
            chan1_match_irq         <= capsel[1] ? (count_run_bit && cap_hit[1])
                                                 : match_evt[1];
            counter_wrap_irq        <= wrap_evt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wrap flag: hardware set beats a clearing write in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst)
            counter_wrap_flag <= 1'b0;
        else if (wrap_evt)
            counter_wrap_flag <= 1'b1;
        else if (opt_wr && !bus.wdata[`FRCCT_OPT_WRAP])
            counter_wrap_flag <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Toggle outputs; invert at start and, in free-running or PWM mode, on each compare match
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            chan0_toggle_out <= 1'b0;
            chan1_toggle_out <= 1'b0;
        end
        else if (start_pulse)
        begin
            chan0_toggle_out <= ~chan0_toggle_out;
            chan1_toggle_out <= ~chan1_toggle_out;
        end
        else if (free_mode || pwm_mode)
        begin
            if (!capsel[0] && match_evt[0])
                chan0_toggle_out <= ~chan0_toggle_out;
            if (!capsel[1] && match_evt[1])
                chan1_toggle_out <= ~chan1_toggle_out;
        end
    end

    // Output enables from the output control register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            chan0_toggle_oe <= 1'b0;
            chan1_toggle_oe <= 1'b0;
        end
        else
        begin
            chan0_toggle_oe <= output_control_reg[`FRCCT_OUT_EN0];
            chan1_toggle_oe <= output_control_reg[`FRCCT_OUT_EN1];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port; unmapped offsets read zero
    always_ff @(posedge clk)
    begin
        if (rst)
            rdata <= `FRCCT_RST_REG16;
        else if (bus.rd)
        begin
            case (bus.addr)
                `FRCCT_OFF_CTL_A:    rdata <= {8'h00, timer_control_reg_a};
                `FRCCT_OFF_CTL_B:    rdata <= {8'h00, timer_control_reg_b};
                `FRCCT_OFF_OUT_CTL:  rdata <= {8'h00, output_control_reg};
                `FRCCT_OFF_EDGE_CTL: rdata <= {8'h00, capture_edge_control_reg};
                `FRCCT_OFF_EXT_CTL:  rdata <= {8'h00, external_input_control_reg};
                `FRCCT_OFF_OPTION:   rdata <= {10'h000, chan1_capture_select,
                                               chan0_capture_select, 3'h0, counter_wrap_flag};
                `FRCCT_OFF_CCR0:     rdata <= ccr[0];
                `FRCCT_OFF_CCR1:     rdata <= ccr[1];
                `FRCCT_OFF_COUNT:    rdata <= count_run_bit ? count : `FRCCT_CNT_ZERO;
                default:             rdata <= `FRCCT_RST_REG16;
            endcase
        end
        else
            rdata <= `FRCCT_RST_REG16;
    end
endmodule // frcct_timer

/* File: frcct_chk.sv */
// Purpose: Port-level assertions for the capture/compare timer
// Assumes: Control bits mirrored from bus writes, count clock select 0
// Notes:   Bound to every frcct_timer instance
`timescale 1ns/10ps
`include "frcct_defines.svh"
module frcct_chk
(
    input wire logic                      clk,                     // Module clock
    input wire logic                      rst,                     // Sync reset
    input wire frcct_pkg::frcct_bus_req_t bus,                     // Register request
    input wire logic [15:0]               rdata,                   // Read data
    input wire logic                      chan1_capture_in,        // Capture pin 1
    input wire logic                      chan0_toggle_out,        // Toggle output 0
    input wire logic                      chan1_toggle_out,        // Toggle output 1
    input wire logic                      chan0_match_capture_irq, // Channel 0 event
    input wire logic                      chan1_match_irq,         // Channel 1 event
    input wire logic                      counter_wrap_irq         // Overflow event
);
    import frcct_pkg::*;
    logic [15:0] ctl_a;
    logic [15:0] ctl_b;
    logic [15:0] opt;
    logic        run_q;
    logic        start;
    logic        free;

    assign start = ctl_a[`FRCCT_CTL_A_RUN] && !run_q;
    assign free  = ctl_b[2:0] == `FRCCT_MODE_FREE;

    ////////////////////////////////////////
    // Control words as software last wrote them
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctl_a <= 16'h0000;
            ctl_b <= 16'h0000;
            opt   <= 16'h0000;
        end
        else if (bus.wr && bus.addr == `FRCCT_OFF_CTL_A)
            ctl_a <= bus.wdata;
        else if (bus.wr && bus.addr == `FRCCT_OFF_CTL_B)
            ctl_b <= bus.wdata;
        else if (bus.wr && bus.addr == `FRCCT_OFF_OPTION)
            opt <= bus.wdata;
    end

    // Delayed run bit, marks the start cycle
    always_ff @(posedge clk)
    begin
        run_q <= !rst && ctl_a[`FRCCT_CTL_A_RUN];
    end

    ////////////////////////////////////////
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    rdata_idle_a: assert property (!bus.rd |=> rdata == 16'h0000)
        else $error("read data not zero outside a read answer");
    start_toggle_a: assert property (start |=> chan0_toggle_out != $past(chan0_toggle_out)
        && chan1_toggle_out != $past(chan1_toggle_out)) else $error("start did not invert outputs");
    match_toggle_a: assert property (chan1_match_irq && free && !opt[`FRCCT_OPT_CCS1]
        |-> chan1_toggle_out != $past(chan1_toggle_out)) else $error("match without toggle");
    toggle_cause_a: assert property (free && $changed(chan0_toggle_out)
        |-> chan0_match_capture_irq || $past(start)) else $error("toggle without cause");
    capture_irq_a: assert property ($rose(chan1_capture_in) && run_q && free && opt[5]
        |-> ##[2:5] chan1_match_irq) else $error("capture event missing");
    wrap_gap_a: assert property (counter_wrap_irq |=> !counter_wrap_irq [*8])
        else $error("overflow event repeated");
    wrap_run_a: assert property (counter_wrap_irq |-> run_q)
        else $error("overflow while stopped");
    irq0_run_a: assert property (chan0_match_capture_irq && !opt[4] |-> run_q)
        else $error("compare event while stopped");

    // Main scenarios reached
    cover property (start);
    cover property (chan1_match_irq && opt[`FRCCT_OPT_CCS1]);
    cover property (counter_wrap_irq);
endmodule // frcct_chk

bind frcct_timer frcct_chk i_chk (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
    .chan1_capture_in(chan1_capture_in), .chan0_toggle_out(chan0_toggle_out),
    .chan1_toggle_out(chan1_toggle_out), .chan0_match_capture_irq(chan0_match_capture_irq),
    .chan1_match_irq(chan1_match_irq), .counter_wrap_irq(counter_wrap_irq));

/* File: frcct_pin_model.sv */
// Purpose: Far-side pulse source for the capture and event pins
// Assumes: Pins are driven at all times, low between pulses
// Notes:   Edges launched right after a rising clock edge
`timescale 1ns/10ps
module frcct_pin_model
(
    input  wire logic clk,  // Module clock
    output logic      cap0, // Capture and event pin 0
    output logic      cap1  // Capture pin 1
);
    initial
    begin
        cap0 = 1'b0;
        cap1 = 1'b0;
    end

    ////////////////////////////////////////
    // One valid rising edge; rises of calls in a row are hi + 1 apart
    task automatic pulse(input int ch, input int hi);
        @(posedge clk);
        if (ch == 0)
            cap0 <= 1'b1;
        else
            cap1 <= 1'b1;
        repeat (hi) @(posedge clk);
        cap0 <= 1'b0;
        cap1 <= 1'b0;
    endtask
endmodule // frcct_pin_model

/* File: testbench.sv */
// Purpose: Self-checking bench for the capture/compare timer
// Assumes: Count clock select 0 except in the event counting case
// Notes:   Event times are edge numbers read at the falling edge
`timescale 1ns/10ps
`include "frcct_defines.svh"
module testbench;
    import frcct_pkg::*;
    logic           clk = 1'b0;
    logic           rst = 1'b1;
    frcct_bus_req_t bus = '0;
    logic [15:0]    rdata;
    logic           cap0;
    logic           cap1;
    logic           tog0;
    logic           tog1;
    logic           oe0;
    logic           oe1;
    logic           irq0;
    logic           irq1;
    logic           irqw;
    logic [15:0]    r;
    logic [15:0]    c1;
    logic           sw_chan1_wrap_note;
    int             mismatches = 0;
    int             check_count = 0;
    int             seed = 66;
    int             cyc = 0;
    int             t_run = 0;
    int             tw = 0;
    int             t;
    int             i0;
    int             d1;

    frcct_timer i_dut (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
        .chan0_capture_in(cap0), .chan1_capture_in(cap1), .chan0_toggle_out(tog0),
        .chan0_toggle_oe(oe0), .chan1_toggle_out(tog1), .chan1_toggle_oe(oe1),
        .chan0_match_capture_irq(irq0), .chan1_match_irq(irq1), .counter_wrap_irq(irqw));
    frcct_pin_model i_pins (.clk(clk), .cap0(cap0), .cap1(cap1));

    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    // Start and wrap stamped mid-cycle, where all has settled
    always @(negedge clk)
    begin
        if (bus.wr && bus.addr == `FRCCT_OFF_CTL_A && bus.wdata[`FRCCT_CTL_A_RUN])
            t_run = cyc + 1;
        if (irqw === 1'b1)
            tw = cyc;
    end

    ////////////////////////////////////////
    task automatic err(input string m);
        mismatches++;
        $display("[ERR] %0t %s", $time, m);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
            $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
        if (got !== exp)
            mismatches++;
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [15:0] q);
        @(posedge clk);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        @(negedge clk);
        q = rdata;
    endtask

    // Bounded wait for one event pulse; t holds its edge number
    task automatic wait_for(input int sel, input int lim);
        int         k;
        logic [2:0] ev;
        for (k = 0; k < lim; k++)
        begin
            @(negedge clk);
            ev = {irqw, irq1, irq0};
            if (ev[sel] === 1'b1)
                break;
        end
        t = cyc;
        if (k == lim)
            err("event pulse missing");
    endtask

    // Two captures n cycles apart; width reckoned the way software would
    task automatic measure(input int n);
        int w;
        fork
            i_pins.pulse(1, n - 1);
            begin
                wait_for(1, 50);
                rd(`FRCCT_OFF_CCR1, c1);
            end
        join
        i_pins.pulse(1, 3);
        wait_for(1, 50);
        rd(`FRCCT_OFF_OPTION, r);
        sw_chan1_wrap_note = r[`FRCCT_OPT_WRAP];
        rd(`FRCCT_OFF_CCR1, r);
        w = int'(r) - int'(c1) + (sw_chan1_wrap_note ? 65536 : 0);
        chk(w, n);
        wr(`FRCCT_OFF_OPTION, 16'h0020);
    endtask

    task automatic print_verdict();
        if (mismatches == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Watchdog: the wrap case alone needs about 66000 cycles
    initial
    begin
        #8000000;
        err("watchdog expired");
        print_verdict();
    end

    ////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd(`FRCCT_OFF_COUNT, r);
        chk(r, 16'h0000);
        wr(4'hF, 16'hFFFF);
        rd(4'hF, r);
        chk(r, 16'h0000);
        // Two compare channels; channel 0 stepped by software
        i0 = 40 + ($unsigned($random(seed)) % 20);
        d1 = i0 + 10 + ($unsigned($random(seed)) % 20);
        wr(`FRCCT_OFF_CTL_B, 16'(`FRCCT_MODE_FREE));
        wr(`FRCCT_OFF_CCR0, 16'(i0 - 1));
        wr(`FRCCT_OFF_CCR1, 16'(d1));
        wr(`FRCCT_OFF_OUT_CTL, 16'h0005);
        wr(`FRCCT_OFF_CTL_A, 16'h0080);
        wait_for(0, 200);
        chk(t - t_run, i0 + 1);
        chk({tog0, oe1, oe0}, 3'h3);
        wr(`FRCCT_OFF_CCR0, 16'(2 * i0 - 1));
        wait_for(1, 100);
        chk(t - t_run, d1 + 2);
        chk(tog1, 1'b0);
        wait_for(0, 100);
        chk(t - t_run, 2 * i0 + 1);
        rd(`FRCCT_OFF_COUNT, r);
        chk(r, 16'(cyc - t_run - 2));
        // Channel 1 event one count earlier in PWM mode
        wr(`FRCCT_OFF_CTL_A, 16'h0000);
        wr(`FRCCT_OFF_CTL_B, 16'(`FRCCT_MODE_PWM));
        wr(`FRCCT_OFF_CCR0, 16'hFFF0);
        wr(`FRCCT_OFF_CTL_A, 16'h0080);
        wait_for(1, 200);
        chk(t - t_run, d1 + 1);
        // Capture on channel 1, then a pair that straddles the wrap
        wr(`FRCCT_OFF_CTL_A, 16'h0000);
        wr(`FRCCT_OFF_CTL_B, 16'(`FRCCT_MODE_FREE));
        wr(`FRCCT_OFF_OPTION, 16'h0020);
        wr(`FRCCT_OFF_EDGE_CTL, 16'h0004);
        wr(`FRCCT_OFF_CCR0, 16'hFF00);
        wr(`FRCCT_OFF_CTL_A, 16'h0080);
        measure(100 + ($unsigned($random(seed)) % 200));
        wait_for(0, 70000);
        chk(t - t_run, 32'hFF02);
        measure(300);
        chk(tw - t_run, 32'h10001);
        rd(`FRCCT_OFF_OPTION, r);
        chk(r, 16'h0020);
        // Event counting ignores the slow clock selection
        wr(`FRCCT_OFF_CTL_A, 16'h0000);
        wr(`FRCCT_OFF_CTL_B, 16'h0045);
        wr(`FRCCT_OFF_EXT_CTL, 16'h0001);
        wr(`FRCCT_OFF_CTL_A, 16'h0087);
        repeat (5) i_pins.pulse(0, 4);
        repeat (6) @(posedge clk);
        rd(`FRCCT_OFF_COUNT, r);
        chk(r, 16'h0004);
        print_verdict();
    end
endmodule // testbench
